//--- shared/lpmc_regs.svh
// Register offsets, field positions, reset values and timing figures of the power-mode sequencer
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH

`define LPMC_OFF_PWR_CTRL       3'h0
`define LPMC_OFF_OSC_CTRL       3'h1
`define LPMC_OFF_REGU_CTRL      3'h2
`define LPMC_OFF_STATUS         3'h3
`define LPMC_OFF_WAKE_CTRL      3'h4

`define LPMC_PWR_STOP_BIT       1
`define LPMC_OSC_SUSPEND_BIT    5
`define LPMC_REGU_STOP_OFF_BIT  0
`define LPMC_WAKE_DET_EN_BIT    0
`define LPMC_WAKE_IRQ_EN_BIT    1
`define LPMC_STAT_STOP_BIT      0
`define LPMC_STAT_SUSPEND_BIT   1
`define LPMC_STAT_REGU_OFF_BIT  2
`define LPMC_STAT_RESET_BIT     3

`define LPMC_RST_CTRL           8'h00
`define LPMC_RESET_VECTOR       16'h0000
`define LPMC_PIN_RST_VAL        3'h2

`define LPMC_CLK_PERIOD_NS      10
`define LPMC_RST_SEQ_NS         100

`endif

//--- shared/lpmc_pkg.sv
// Types shared by the power-mode sequencer
package lpmc_pkg;

  typedef enum logic [1:0] {
    S_RSTSEQ,
    S_RUN,
    S_STOP,
    S_SUSP
  } lpmc_state_t;

  typedef struct packed {
    logic int_osc_en;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic regulator_en;
  } lpmc_gate_t;

endpackage

//--- hdl/lpmc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulse
`timescale 1ns/1ps

module lpmc_pin_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] edge_pulse
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff         <= RST_VAL[i];
          s2_ff         <= RST_VAL[i];
          s3_ff         <= RST_VAL[i];
          level[i]      <= RST_VAL[i];
          edge_pulse[i] <= 1'b0;
        end else begin
          s1_ff         <= pin_in[i];
          s2_ff         <= s1_ff;
          s3_ff         <= s2_ff;
          // A change counts only once the last two stages agree
          edge_pulse[i] <= (s2_ff == s3_ff) && (s3_ff != level[i]);
          if (s2_ff == s3_ff) begin
            level[i] <= s3_ff;
          end
        end
      end
    end
  endgenerate

endmodule

//--- hdl/lpmc_top.sv
// Low-power mode sequencer: stop and suspend control, reset sequence and clock gating
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "lpmc_regs.svh"

module lpmc_top (
  input  wire logic                CLK,
  input  wire logic                RSTN,
  input  wire logic [2:0]          ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [7:0]          RDATA,
  input  wire logic                INSN_DONE,
  input  wire logic                SYSCLK_IS_HF,
  input  wire logic                OTHER_RST_REQ,
  input  wire logic                WAKE_EDGE_PIN,
  input  wire logic                RST_PIN_N,
  input  wire logic                CLK_DET_TIMEOUT,
  output lpmc_pkg::lpmc_gate_t     GATES,
  output logic                     CORE_RESET,
  output logic      [15:0]         RESET_VECTOR,
  output logic                     RESUME,
  output logic                     WAKE_IRQ
);

  localparam int RstSeqCyc = (`LPMC_RST_SEQ_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS;
  localparam logic [7:0] RstSeqLast = 8'(RstSeqCyc - 1);
  // Control reset value as a named constant so that single bits can be selected from it
  localparam logic [7:0] RstCtrl    = `LPMC_RST_CTRL;

  lpmc_pkg::lpmc_state_t state_ff;
  lpmc_pkg::lpmc_state_t nxt_state;
  lpmc_pkg::lpmc_gate_t  nxt_gates;
  logic [7:0] cnt_ff;
  logic [2:0] pin_lvl;
  logic [2:0] pin_edge;
  logic       stop_ff;
  logic       suspend_ff;
  logic       stop_off_cfg_ff;
  logic       det_en_ff;
  logic       wake_irq_en_ff;
  logic       regoff_ff;
  logic       nxt_regoff;
  logic       rst_pin_act;
  logic       det_timeout;
  logic       wake_edge;
  logic       rst_take;
  logic [7:0] status;

  lpmc_pin_sync #(
    .WIDTH   (3),
    .RST_VAL (`LPMC_PIN_RST_VAL)
  ) u_pin_sync (
    .clk        (CLK),
    .rst_n      (RSTN),
    .pin_in     ({CLK_DET_TIMEOUT, RST_PIN_N, WAKE_EDGE_PIN}),
    .level      (pin_lvl),
    .edge_pulse (pin_edge)
  );

  assign wake_edge   = pin_edge[0];
  assign rst_pin_act = !pin_lvl[1];
  assign det_timeout = pin_lvl[2];

  // With the regulator down only the reset pin is heard
  assign rst_take = rst_pin_act
                  | (!regoff_ff & (OTHER_RST_REQ | (det_timeout & det_en_ff)));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lpmc_pkg::S_RSTSEQ: begin
        if (!rst_take && cnt_ff == RstSeqLast) begin
          nxt_state = lpmc_pkg::S_RUN;
        end
      end
      lpmc_pkg::S_RUN: begin
        if (rst_take) begin
          nxt_state = lpmc_pkg::S_RSTSEQ;
        end else if (INSN_DONE && stop_ff) begin
          nxt_state = lpmc_pkg::S_STOP;
        end else if (INSN_DONE && suspend_ff) begin
          nxt_state = lpmc_pkg::S_SUSP;
        end
      end
      lpmc_pkg::S_STOP: begin
        if (rst_take) begin
          nxt_state = lpmc_pkg::S_RSTSEQ;
        end
      end
      lpmc_pkg::S_SUSP: begin
        if (rst_take) begin
          nxt_state = lpmc_pkg::S_RSTSEQ;
        end else if (wake_edge) begin
          nxt_state = lpmc_pkg::S_RUN;
        end
      end
      default: begin
        nxt_state = lpmc_pkg::S_RSTSEQ;
      end
    endcase
  end

  // Regulator shutdown is decided once, at stop entry
  always_comb begin
    nxt_regoff = 1'b0;
    if (state_ff == lpmc_pkg::S_RUN && nxt_state == lpmc_pkg::S_STOP) begin
      nxt_regoff = stop_off_cfg_ff;
    end else if (state_ff == lpmc_pkg::S_STOP && nxt_state == lpmc_pkg::S_STOP) begin
      nxt_regoff = regoff_ff;
    end
  end

  always_comb begin
    nxt_gates = '{int_osc_en: 1'b1, cpu_clk_en: 1'b1, periph_clk_en: 1'b1, regulator_en: 1'b1};
    case (nxt_state)
      lpmc_pkg::S_STOP: begin
        nxt_gates.int_osc_en    = 1'b0;
        nxt_gates.cpu_clk_en    = 1'b0;
        nxt_gates.periph_clk_en = 1'b0;
        nxt_gates.regulator_en  = !nxt_regoff;
      end
      lpmc_pkg::S_SUSP: begin
        nxt_gates.int_osc_en = 1'b0;
        // CPU keeps running unless its only clock is the halted oscillator
        nxt_gates.cpu_clk_en = !SYSCLK_IS_HF;
      end
      default: begin
        nxt_gates.int_osc_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff  <= lpmc_pkg::S_RSTSEQ;
      regoff_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      regoff_ff <= nxt_regoff;
    end
  end

  // Reset sequence length; a reset still asserted restarts it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_ff <= 8'h00;
    end else if (state_ff != lpmc_pkg::S_RSTSEQ || rst_take) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != RstSeqLast) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Control bits; the reset sequence returns them to defaults
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      stop_ff         <= RstCtrl[`LPMC_PWR_STOP_BIT];
      suspend_ff      <= RstCtrl[`LPMC_OSC_SUSPEND_BIT];
      stop_off_cfg_ff <= RstCtrl[`LPMC_REGU_STOP_OFF_BIT];
      det_en_ff       <= RstCtrl[`LPMC_WAKE_DET_EN_BIT];
      wake_irq_en_ff  <= RstCtrl[`LPMC_WAKE_IRQ_EN_BIT];
    end else if (nxt_state == lpmc_pkg::S_RSTSEQ) begin
      stop_ff         <= RstCtrl[`LPMC_PWR_STOP_BIT];
      suspend_ff      <= RstCtrl[`LPMC_OSC_SUSPEND_BIT];
      stop_off_cfg_ff <= RstCtrl[`LPMC_REGU_STOP_OFF_BIT];
      det_en_ff       <= RstCtrl[`LPMC_WAKE_DET_EN_BIT];
      wake_irq_en_ff  <= RstCtrl[`LPMC_WAKE_IRQ_EN_BIT];
    end else begin
      if (WR && ADDR == `LPMC_OFF_PWR_CTRL) begin
        stop_ff <= WDATA[`LPMC_PWR_STOP_BIT];
      end
      if (WR && ADDR == `LPMC_OFF_OSC_CTRL) begin
        suspend_ff <= WDATA[`LPMC_OSC_SUSPEND_BIT];
      end else if (state_ff == lpmc_pkg::S_SUSP && nxt_state == lpmc_pkg::S_RUN) begin
        suspend_ff <= 1'b0;
      end
      if (WR && ADDR == `LPMC_OFF_REGU_CTRL) begin
        stop_off_cfg_ff <= WDATA[`LPMC_REGU_STOP_OFF_BIT];
      end
      if (WR && ADDR == `LPMC_OFF_WAKE_CTRL) begin
        det_en_ff      <= WDATA[`LPMC_WAKE_DET_EN_BIT];
        wake_irq_en_ff <= WDATA[`LPMC_WAKE_IRQ_EN_BIT];
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[`LPMC_STAT_STOP_BIT]     = (state_ff == lpmc_pkg::S_STOP);
    status[`LPMC_STAT_SUSPEND_BIT]  = (state_ff == lpmc_pkg::S_SUSP);
    status[`LPMC_STAT_REGU_OFF_BIT] = regoff_ff;
    status[`LPMC_STAT_RESET_BIT]    = (state_ff == lpmc_pkg::S_RSTSEQ);
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `LPMC_OFF_PWR_CTRL:  RDATA <= 8'(stop_ff) << `LPMC_PWR_STOP_BIT;
        `LPMC_OFF_OSC_CTRL:  RDATA <= 8'(suspend_ff) << `LPMC_OSC_SUSPEND_BIT;
        `LPMC_OFF_REGU_CTRL: RDATA <= 8'(stop_off_cfg_ff) << `LPMC_REGU_STOP_OFF_BIT;
        `LPMC_OFF_STATUS:    RDATA <= status;
        `LPMC_OFF_WAKE_CTRL: RDATA <= (8'(det_en_ff) << `LPMC_WAKE_DET_EN_BIT)
                                    | (8'(wake_irq_en_ff) << `LPMC_WAKE_IRQ_EN_BIT);
        default:             RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      GATES        <= '{int_osc_en: 1'b1, cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                        regulator_en: 1'b1};
      CORE_RESET   <= 1'b1;
      RESET_VECTOR <= `LPMC_RESET_VECTOR;
    end else begin
      GATES        <= nxt_gates;
      CORE_RESET   <= (nxt_state == lpmc_pkg::S_RSTSEQ);
      RESET_VECTOR <= `LPMC_RESET_VECTOR;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RESUME   <= 1'b0;
      WAKE_IRQ <= 1'b0;
    end else begin
      RESUME   <= state_ff == lpmc_pkg::S_SUSP && nxt_state == lpmc_pkg::S_RUN
                  && SYSCLK_IS_HF;
      WAKE_IRQ <= state_ff == lpmc_pkg::S_SUSP && nxt_state == lpmc_pkg::S_RUN
                  && wake_irq_en_ff;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_stop_entry: assert property (
    state_ff == lpmc_pkg::S_RUN && INSN_DONE && stop_ff && !rst_take
    |=> state_ff == lpmc_pkg::S_STOP && !GATES.cpu_clk_en)
    else $error("stop not entered after instruction completion");

  a_stop_gates: assert property (
    state_ff == lpmc_pkg::S_STOP
    |-> !GATES.int_osc_en && !GATES.cpu_clk_en && !GATES.periph_clk_en)
    else $error("clocks running in stop mode");

  a_stop_hold: assert property (
    state_ff == lpmc_pkg::S_STOP && !rst_take && (wake_edge || INSN_DONE)
    |=> state_ff == lpmc_pkg::S_STOP)
    else $error("stop mode left without reset");

  a_reset_vector: assert property (
    $fell(CORE_RESET) |-> state_ff == lpmc_pkg::S_RUN && RESET_VECTOR == 16'h0000
    && $past(cnt_ff) == RstSeqLast)
    else $error("reset sequence ended wrongly");

  a_detector_reset: assert property (
    state_ff == lpmc_pkg::S_STOP && det_timeout && det_en_ff && !regoff_ff
    |=> CORE_RESET && state_ff == lpmc_pkg::S_RSTSEQ)
    else $error("detector timeout did not reset stop mode");

  a_regulator_default: assert property (
    state_ff == lpmc_pkg::S_STOP && !regoff_ff |-> GATES.regulator_en)
    else $error("regulator off without shutdown option");

  a_regulator_off: assert property (
    state_ff == lpmc_pkg::S_RUN && nxt_state == lpmc_pkg::S_STOP && stop_off_cfg_ff
    |=> !GATES.regulator_en [*2] or (!GATES.regulator_en ##1 CORE_RESET))
    else $error("regulator not shut down in stop");

  a_regulator_ignore: assert property (
    state_ff == lpmc_pkg::S_STOP && regoff_ff && !rst_pin_act
    |=> state_ff == lpmc_pkg::S_STOP)
    else $error("non-pin reset accepted with regulator off");

  a_suspend_entry: assert property (
    state_ff == lpmc_pkg::S_RUN && INSN_DONE && suspend_ff && !stop_ff && !rst_take
    |=> state_ff == lpmc_pkg::S_SUSP && !GATES.int_osc_en)
    else $error("suspend not entered");

  a_suspend_cpu: assert property (
    state_ff == lpmc_pkg::S_RUN ##1 state_ff == lpmc_pkg::S_SUSP
    |-> GATES.cpu_clk_en == !$past(SYSCLK_IS_HF) && GATES.periph_clk_en)
    else $error("CPU halted in suspend");

  a_wake_exit: assert property (
    state_ff == lpmc_pkg::S_SUSP && wake_edge && !rst_take
    |=> state_ff == lpmc_pkg::S_RUN && !suspend_ff ##1 state_ff != lpmc_pkg::S_SUSP)
    else $error("wake edge did not end suspend");

  a_resume: assert property (
    state_ff == lpmc_pkg::S_SUSP && wake_edge && !rst_take && SYSCLK_IS_HF
    |=> RESUME ##1 !RESUME)
    else $error("resume pulse missing");

  a_wake_irq: assert property (
    $rose(WAKE_IRQ) |-> $past(state_ff) == lpmc_pkg::S_SUSP && state_ff == lpmc_pkg::S_RUN
    && $past(wake_irq_en_ff))
    else $error("wake interrupt without enabled wake");

  a_strobe_gate: assert property (
    state_ff == lpmc_pkg::S_RUN && !INSN_DONE && !rst_take |=> state_ff == lpmc_pkg::S_RUN)
    else $error("mode change without instruction strobe");

  c_stop_reset: cover property (
    state_ff == lpmc_pkg::S_STOP ##1 state_ff == lpmc_pkg::S_RSTSEQ);
  c_stop_regoff: cover property (state_ff == lpmc_pkg::S_STOP && regoff_ff);
  c_suspend_wake: cover property (
    state_ff == lpmc_pkg::S_SUSP ##1 state_ff == lpmc_pkg::S_RUN ##0 WAKE_IRQ);

endmodule

//--- verif/lpmc_core_model.sv
// Core model: instruction-complete strobes, clock source choice and restart address
`timescale 1ns/1ps

module lpmc_core_model (
  input  wire logic        clk,
  input  wire logic        core_reset,
  input  wire logic [15:0] reset_vector,
  output logic             insn_done,
  output logic             sysclk_is_hf,
  output logic [15:0]      pc
);
  initial begin
    insn_done    = 1'b0;
    sysclk_is_hf = 1'b1;
  end

  // Restart from the reset vector, then step once per finished instruction
  always_ff @(posedge clk) begin
    if (core_reset) begin
      pc <= reset_vector;
    end else if (insn_done) begin
      pc <= pc + 16'h0001;
    end
  end

  // One instruction completes; the strobe waits up to 50 cycles for a held core to leave reset
  task automatic insn();
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
    @(posedge clk);
  endtask

  task automatic set_hf(input logic hf);
    sysclk_is_hf <= hf;
    @(posedge clk);
  endtask
endmodule

//--- verif/test_low_power_mode_control.sv
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ps

module test_low_power_mode_control;
  logic                 clk, rstn, wr, rd, other_rst, wake_pin, rst_pin_n, det_to;
  logic                 insn_done, hf, core_reset, resume, wake_irq;
  logic [2:0]           addr;
  logic [7:0]           wdata, rdata;
  logic [15:0]          rst_vec, pc;
  lpmc_pkg::lpmc_gate_t gates;
  int                   n_mismatch, n_compared;

  always #5 clk = ~clk;

  lpmc_top lpmc_top_i (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .INSN_DONE(insn_done), .SYSCLK_IS_HF(hf), .OTHER_RST_REQ(other_rst),
    .WAKE_EDGE_PIN(wake_pin), .RST_PIN_N(rst_pin_n), .CLK_DET_TIMEOUT(det_to),
    .GATES(gates), .CORE_RESET(core_reset), .RESET_VECTOR(rst_vec), .RESUME(resume),
    .WAKE_IRQ(wake_irq)
  );

  lpmc_core_model lpmc_core_model_i (
    .clk(clk), .core_reset(core_reset), .reset_vector(rst_vec), .insn_done(insn_done),
    .sysclk_is_hf(hf), .pc(pc)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask

  task automatic gate(input logic [3:0] e);
    #1;
    chk({12'h000, gates}, {12'h000, e});
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (core_reset !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) n_mismatch++;
    @(posedge clk);
  endtask

  // Toggle the wake pin and collect the one-cycle wake pulses
  task automatic wake(input logic er, input logic ei);
    logic sr, si;
    sr = 1'b0;
    si = 1'b0;
    wake_pin <= ~wake_pin;
    repeat (10) begin
      @(posedge clk);
      #1;
      sr |= resume;
      si |= wake_irq;
    end
    @(posedge clk);
    chk({15'h0000, sr}, {15'h0000, er});
    chk({15'h0000, si}, {15'h0000, ei});
  endtask

  // Source 0 internal request, 1 reset pin, 2 detector timeout
  task automatic rst_src(input int src, input logic e);
    logic hit;
    hit = 1'b0;
    if (src == 0) other_rst <= 1'b1;
    else if (src == 1) rst_pin_n <= 1'b0;
    else det_to <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1;
      hit |= core_reset;
    end
    @(posedge clk);
    other_rst <= 1'b0;
    rst_pin_n <= 1'b1;
    det_to <= 1'b0;
    repeat (6) @(posedge clk);
    chk({15'h0000, hit}, {15'h0000, e});
    if (e) begin
      wait_idle();
      gate(4'hf);
      reg_rd(3'h0, 8'h00);
      reg_rd(3'h3, 8'h00);
      chk(pc, 16'h0000);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_mismatch);
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests need well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    other_rst = 1'b0;
    wake_pin = 1'b0;
    rst_pin_n = 1'b1;
    det_to = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wait_idle();
    chk(rst_vec, 16'h0000);
    chk(pc, 16'h0000);
    for (int a = 0; a < 6; a++) reg_rd(a[2:0], 8'h00);
    reg_wr(3'h3, 8'hff);
    reg_rd(3'h3, 8'h00);
    end_test("reset");
    reg_wr(3'h0, 8'h02); // Detector left off for a long stop
    gate(4'hf);
    lpmc_core_model_i.insn();
    gate(4'h1);
    reg_rd(3'h3, 8'h01);
    wake(1'b0, 1'b0);
    lpmc_core_model_i.insn();
    gate(4'h1);
    rst_src(0, 1'b1);
    end_test("stop");
    reg_wr(3'h4, 8'h01);
    reg_wr(3'h0, 8'h02);
    lpmc_core_model_i.insn();
    gate(4'h1);
    rst_src(2, 1'b1);
    end_test("detector");
    reg_wr(3'h4, 8'h01);
    reg_wr(3'h2, 8'h01); // Shutdown chosen before the stop bit
    reg_wr(3'h0, 8'h02);
    lpmc_core_model_i.insn();
    gate(4'h0);
    reg_rd(3'h3, 8'h05);
    rst_src(0, 1'b0);
    rst_src(2, 1'b0);
    rst_src(1, 1'b1);
    end_test("regulator");
    lpmc_core_model_i.set_hf(1'b1);
    reg_wr(3'h4, 8'h02);
    reg_wr(3'h1, 8'h20);
    lpmc_core_model_i.insn();
    gate(4'h3);
    reg_rd(3'h3, 8'h02);
    wake(1'b1, 1'b1);
    gate(4'hf);
    reg_rd(3'h1, 8'h00);
    reg_rd(3'h4, 8'h02);
    end_test("suspend_hf");
    lpmc_core_model_i.set_hf(1'b0);
    reg_wr(3'h4, 8'h00);
    reg_wr(3'h1, 8'h20);
    lpmc_core_model_i.insn();
    gate(4'h7);
    reg_wr(3'h2, 8'h01);
    reg_rd(3'h2, 8'h01);
    wake(1'b0, 1'b0);
    gate(4'hf);
    reg_rd(3'h2, 8'h01);
    reg_wr(3'h1, 8'h20);
    lpmc_core_model_i.insn();
    rst_src(1, 1'b1);
    end_test("suspend_other");
    reg_wr(3'h0, 8'h02);
    reg_wr(3'h1, 8'h20);
    lpmc_core_model_i.insn();
    gate(4'h1);
    reg_rd(3'h3, 8'h01);
    rst_src(1, 1'b1);
    end_test("priority");
    final_report();
  end
endmodule
